//--- verilog/iwdt_pkg.sv
// Constants and types shared by the indexed-port watchdog timer
package iwdt_pkg;
  // I/O locations of the configuration port pair
  localparam logic [15:0] INDEX_PORT = 16'h002E;
  localparam logic [15:0] DATA_PORT = 16'h002F;
  // Keys written to the index port
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK = 8'hAA;
  // Register indices
  localparam logic [7:0] REG_GROUP_SEL = 8'h07;
  localparam logic [7:0] REG_ACTIVATE = 8'h30;
  localparam logic [7:0] REG_UNIT_SEL = 8'hF5;
  localparam logic [7:0] REG_COUNT = 8'hF6;
  localparam logic [7:0] REG_CTRL_STAT = 8'hF7;
  localparam logic [7:0] WDT_GROUP = 8'h08;
  // Field positions
  localparam int ACT_EN_BIT = 0;
  localparam int UNIT_MIN_BIT = 3;
  localparam int UNIT_FAST_BIT = 4;
  localparam int CTL_MOUSE_BIT = 7;
  localparam int CTL_KBD_BIT = 6;
  localparam int CTL_FORCE_BIT = 5;
  localparam int CTL_STAT_BIT = 4;
  // Reset values
  localparam logic [7:0] GROUP_RST = 8'h00;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [7:0] UNIT_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [1:0] CTL_RST = 2'h0;
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] OPEN_BUS = 8'hFF;
  // Timing: one base tick is one millisecond
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned BASE_TICK_NS = 1000000;
  localparam int unsigned CYC_PER_MS = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MS_PER_SEC = 16'h03E8;
  localparam logic [15:0] MS_PER_MIN = 16'hEA60;
  localparam logic [15:0] FAST_MS_PER_SEC = 16'h0001;
  localparam logic [15:0] FAST_MS_PER_MIN = 16'h003C;
  // One I/O cycle from the host side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } iwdt_io_t;
endpackage : iwdt_pkg

//--- verilog/iwdt_top.sv
// Watchdog timer behind an indexed address/data configuration port pair
module iwdt_top import iwdt_pkg::*; #(
  parameter int unsigned P_CYC_PER_MS = CYC_PER_MS
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire iwdt_io_t i_io,
  input wire logic i_kbd_act,
  output logic [7:0] o_io_rdata,
  output logic o_wdt_timeout,
  output logic o_cfg_mode
);

  logic cfg_ff;
  logic last_key_ff;
  logic [7:0] idx_ff;
  logic [7:0] group_ff;
  logic [7:0] act_ff;
  logic [7:0] unit_ff;
  logic [7:0] load_ff;
  logic [1:0] ctl_ff;
  logic stat_ff;
  logic [7:0] cnt_ff;
  logic [17:0] pre_ff;
  logic [15:0] sub_ff;
  logic [7:0] rdata_ff;
  logic kb_s1_ff;
  logic kb_s2_ff;
  logic kb_s3_ff;

  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic wdt_sel;
  logic wr_group;
  logic wr_act;
  logic wr_unit;
  logic wr_cnt;
  logic wr_ctl;
  logic force_to;
  logic kbd_edge;
  logic kbd_restart;
  logic restart;
  logic running;
  logic ms_tick;
  logic cnt_tick;
  logic expire;
  logic [15:0] unit_len;
  logic [7:0] nxt_rdata;

  // Port decode; data accesses count only while unlocked
  assign idx_wr = i_io.wr && (i_io.addr == INDEX_PORT);
  assign dat_wr = i_io.wr && (i_io.addr == DATA_PORT) && cfg_ff;
  assign dat_rd = i_io.rd && (i_io.addr == DATA_PORT) && cfg_ff;
  assign wdt_sel = (group_ff == WDT_GROUP);
  assign wr_group = dat_wr && (idx_ff == REG_GROUP_SEL);
  assign wr_act = dat_wr && wdt_sel && (idx_ff == REG_ACTIVATE);
  assign wr_unit = dat_wr && wdt_sel && (idx_ff == REG_UNIT_SEL);
  assign wr_cnt = dat_wr && wdt_sel && (idx_ff == REG_COUNT);
  assign wr_ctl = dat_wr && wdt_sel && (idx_ff == REG_CTRL_STAT);
  assign force_to = wr_ctl && i_io.data[CTL_FORCE_BIT];

  // Unlock and lock key detection
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      last_key_ff <= 1'b0;
    end else if (idx_wr) begin
      last_key_ff <= !cfg_ff && (i_io.data == KEY_UNLOCK) && !last_key_ff;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cfg_ff <= 1'b0;
    end else if (idx_wr && !cfg_ff && last_key_ff && (i_io.data == KEY_UNLOCK)) begin
      cfg_ff <= 1'b1;
    end else if (idx_wr && cfg_ff && (i_io.data == KEY_LOCK)) begin
      cfg_ff <= 1'b0;
    end
  end

  // The index is only taken while unlocked, so key writes never disturb it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      idx_ff <= IDX_RST;
    end else if (idx_wr && cfg_ff && (i_io.data != KEY_LOCK)) begin
      idx_ff <= i_io.data;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      group_ff <= GROUP_RST;
    end else if (wr_group) begin
      group_ff <= i_io.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      act_ff <= ACT_RST;
    end else if (wr_act) begin
      act_ff <= i_io.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      unit_ff <= UNIT_RST;
    end else if (wr_unit) begin
      unit_ff <= i_io.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      load_ff <= COUNT_RST;
    end else if (wr_cnt) begin
      load_ff <= i_io.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctl_ff <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_ff <= {i_io.data[CTL_MOUSE_BIT], i_io.data[CTL_KBD_BIT]};
    end
  end

  // Keyboard strobe comes from a pin: two stages, then edge detect
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      kb_s1_ff <= 1'b0;
      kb_s2_ff <= 1'b0;
      kb_s3_ff <= 1'b0;
    end else begin
      kb_s1_ff <= i_kbd_act;
      kb_s2_ff <= kb_s1_ff;
      kb_s3_ff <= kb_s2_ff;
    end
  end

  assign kbd_edge = kb_s2_ff && !kb_s3_ff;
  assign kbd_restart = kbd_edge && ctl_ff[0] && act_ff[ACT_EN_BIT];
  assign restart = wr_cnt || kbd_restart;

  // Milliseconds per count, from the unit and speed bits
  always_comb begin
    if (unit_ff[UNIT_FAST_BIT]) begin
      unit_len = unit_ff[UNIT_MIN_BIT] ? FAST_MS_PER_MIN : FAST_MS_PER_SEC;
    end else begin
      unit_len = unit_ff[UNIT_MIN_BIT] ? MS_PER_MIN : MS_PER_SEC;
    end
  end

  assign running = act_ff[ACT_EN_BIT] && (cnt_ff != 8'h00);
  assign ms_tick = running && (pre_ff == 18'(P_CYC_PER_MS - 1));
  assign cnt_tick = ms_tick && (sub_ff == unit_len - 16'h0001);
  assign expire = cnt_tick && (cnt_ff == 8'h01) && !restart;

  // Prescalers restart with the countdown so a reload gives a full first count
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || restart || !running || ms_tick) begin
      pre_ff <= 18'h00000;
    end else begin
      pre_ff <= pre_ff + 18'h00001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || restart || !running || cnt_tick) begin
      sub_ff <= 16'h0000;
    end else if (ms_tick) begin
      sub_ff <= sub_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cnt_ff <= COUNT_RST;
    end else if (wr_cnt) begin
      cnt_ff <= i_io.data;
    end else if (kbd_restart) begin
      cnt_ff <= load_ff;
    end else if (cnt_tick) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // Status stays set until software writes 0 to it; a new event wins over the clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      stat_ff <= 1'b0;
    end else if (expire || force_to) begin
      stat_ff <= 1'b1;
    end else if (wr_ctl && !i_io.data[CTL_STAT_BIT]) begin
      stat_ff <= 1'b0;
    end
  end

  // Read path; the index port always reads back; locked or unmapped data-port reads see an open bus
  always_comb begin
    nxt_rdata = OPEN_BUS;
    if (i_io.addr == INDEX_PORT) begin
      nxt_rdata = idx_ff;
    end else if (!dat_rd) begin
      nxt_rdata = OPEN_BUS;
    end else if (idx_ff == REG_GROUP_SEL) begin
      nxt_rdata = group_ff;
    end else if (!wdt_sel) begin
      nxt_rdata = OPEN_BUS;
    end else if (idx_ff == REG_ACTIVATE) begin
      nxt_rdata = act_ff;
    end else if (idx_ff == REG_UNIT_SEL) begin
      nxt_rdata = unit_ff;
    end else if (idx_ff == REG_COUNT) begin
      nxt_rdata = load_ff;
    end else if (idx_ff == REG_CTRL_STAT) begin
      nxt_rdata = {ctl_ff, 1'b0, stat_ff, 4'h0};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_ff <= RDATA_RST;
    end else if (i_io.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_io_rdata = rdata_ff;
  assign o_wdt_timeout = stat_ff;
  assign o_cfg_mode = cfg_ff;

  a_unlock_pair: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (idx_wr && i_io.data == KEY_UNLOCK && !cfg_ff) ##1 !idx_wr ##1
    (idx_wr && i_io.data == KEY_UNLOCK) |=> cfg_ff)
    else $error("unlock key pair did not open configuration");

  a_lock_key: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (cfg_ff && idx_wr && i_io.data == KEY_LOCK) |=> !cfg_ff)
    else $error("lock key did not close configuration");

  a_locked_ignore: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!cfg_ff && !kbd_restart && !cnt_tick) |=>
    ($stable(load_ff) && $stable(act_ff) && $stable(cnt_ff) && $stable(group_ff)))
    else $error("locked port changed a register");

  a_index_take: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (cfg_ff && idx_wr && i_io.data != KEY_LOCK) |=> (idx_ff == $past(i_io.data)))
    else $error("index port write not captured");

  a_group_gate: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_io.wr && i_io.addr == DATA_PORT && group_ff != WDT_GROUP) |=> $stable(act_ff))
    else $error("watchdog register written without group select");

  a_count_reload: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_cnt |=> (cnt_ff == $past(i_io.data)) && (pre_ff == 18'h00000))
    else $error("count write did not restart countdown");

  a_zero_stops: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (cnt_ff == 8'h00 && !restart && !force_to) |=> (cnt_ff == 8'h00) && !$rose(stat_ff))
    else $error("timer ran with zero count");

  a_disabled_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!act_ff[ACT_EN_BIT] && !wr_cnt) |=> $stable(cnt_ff) && (pre_ff == 18'h00000))
    else $error("disabled watchdog counted");

  a_expiry_flag: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    expire |=> stat_ff && o_wdt_timeout && (cnt_ff == 8'h00))
    else $error("expiry did not raise timeout");

  a_force_now: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    force_to |=> o_wdt_timeout)
    else $error("forced timeout not produced");

  a_kbd_effect: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (kbd_edge && ctl_ff[0] && act_ff[ACT_EN_BIT] && !wr_cnt) |=> (cnt_ff == $past(load_ff)))
    else $error("keyboard did not restart timer");

  a_unit_len: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    cnt_tick |-> (unit_ff[UNIT_FAST_BIT] ? (sub_ff < 16'h003C) : (sub_ff >= 16'h03E7)))
    else $error("count length does not match unit");

  a_status_read: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (dat_rd && wdt_sel && idx_ff == REG_CTRL_STAT) |=>
    (o_io_rdata[CTL_STAT_BIT] == $past(stat_ff)) && !o_io_rdata[CTL_FORCE_BIT])
    else $error("status bit misreported");

endmodule : iwdt_top

//--- tb/iwdt_host.sv
// Host-side model that issues I/O cycles on the configuration port pair
module iwdt_host import iwdt_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output iwdt_io_t o_io
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_io = '0;

  // A released bus shows the inverse of its last contents, never a stale copy
  task automatic put(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_io <= '{wr, !wr, a, d};
    @(posedge i_clk_sys);
    o_io <= '{1'b0, 1'b0, ~a, ~d};
    // Return off the edge so callers see outputs that have settled
    @(negedge i_clk_sys);
  endtask : put

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    put(1'b1, INDEX_PORT, idx);
    put(1'b1, DATA_PORT, val);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] val);
    put(1'b1, INDEX_PORT, idx);
    put(1'b0, DATA_PORT, 8'h00);
    val = i_rdata;
  endtask : reg_rd

  task automatic unlock;
    put(1'b1, INDEX_PORT, KEY_UNLOCK);
    put(1'b1, INDEX_PORT, KEY_UNLOCK);
  endtask : unlock

  task automatic lock;
    put(1'b1, INDEX_PORT, KEY_LOCK);
  endtask : lock
endmodule : iwdt_host

//--- tb/testbench.sv
// Self-checking testbench for the indexed-port watchdog timer
module testbench import iwdt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic i_kbd_act = 1'b0;
  iwdt_io_t io;
  logic [7:0] o_io_rdata;
  logic o_wdt_timeout;
  logic o_cfg_mode;
  logic [7:0] rv;
  int err_total = 0;
  int compares = 0;

  always #2 i_clk_sys = ~i_clk_sys;

  iwdt_host i_host (.i_clk_sys(i_clk_sys), .i_rdata(o_io_rdata), .o_io(io));
  // Shortened millisecond so that full counts stay short
  iwdt_top #(.P_CYC_PER_MS(4)) i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_io(io),
    .i_kbd_act(i_kbd_act), .o_io_rdata(o_io_rdata), .o_wdt_timeout(o_wdt_timeout),
    .o_cfg_mode(o_cfg_mode));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    i_host.reg_rd(idx, rv);
    chk(rv, exp, msg);
  endtask : rd_chk

  // Counts cycles until the timeout output rises; it must land inside [lo, hi]
  task automatic tmo_in(input int lo, input int hi, input string msg);
    int n;
    n = 0;
    while (o_wdt_timeout !== 1'b1 && n < hi) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk({7'h00, o_wdt_timeout}, 8'h01, msg);
    if (n < lo) chk(8'h00, 8'h01, "timeout too early");
  endtask : tmo_in

  task automatic idle_no_tmo(input int n, input string msg);
    repeat (n) @(negedge i_clk_sys);
    chk({7'h00, o_wdt_timeout}, 8'h00, msg);
  endtask : idle_no_tmo

  task automatic kbd_pulse;
    @(posedge i_clk_sys);
    i_kbd_act <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_kbd_act <= 1'b0;
  endtask : kbd_pulse

  task automatic s_reset_unlock;
    chk({6'h00, o_cfg_mode, o_wdt_timeout}, 8'h00, "reset outputs");
    chk(o_io_rdata, RDATA_RST, "reset rdata");
    rd_chk(REG_COUNT, OPEN_BUS, "locked read");
    i_host.unlock();
    chk({7'h00, o_cfg_mode}, 8'h01, "unlock");
    rd_chk(REG_ACTIVATE, OPEN_BUS, "group not selected");
    i_host.reg_wr(REG_GROUP_SEL, WDT_GROUP);
    rd_chk(REG_ACTIVATE, ACT_RST, "activate reset");
    rd_chk(REG_UNIT_SEL, UNIT_RST, "unit reset");
    rd_chk(REG_COUNT, COUNT_RST, "count reset");
    rd_chk(REG_CTRL_STAT, 8'h00, "ctrl reset");
    rd_chk(8'h55, OPEN_BUS, "unmapped read");
    // A short loaded count that must not run while the function is off
    i_host.reg_wr(REG_UNIT_SEL, 8'h10);
    i_host.reg_wr(REG_COUNT, 8'h02);
    idle_no_tmo(40, "disabled timer");
    i_host.reg_wr(REG_COUNT, 8'h00);
  endtask : s_reset_unlock

  task automatic s_expire;
    i_host.reg_wr(REG_ACTIVATE, 8'h01);
    i_host.reg_wr(REG_UNIT_SEL, 8'h10);
    i_host.reg_wr(REG_COUNT, 8'h05);
    tmo_in(19, 24, "fast seconds expiry");
    rd_chk(REG_CTRL_STAT, 8'h10, "status set");
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
    chk({7'h00, o_wdt_timeout}, 8'h00, "status clear");
    i_host.reg_wr(REG_COUNT, 8'h05);
    idle_no_tmo(12, "before restart");
    i_host.reg_wr(REG_COUNT, 8'h05);
    tmo_in(19, 24, "restart by rewrite");
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
  endtask : s_expire

  task automatic s_keyboard;
    i_host.reg_wr(REG_COUNT, 8'h05);
    idle_no_tmo(10, "kbd off wait");
    kbd_pulse();
    tmo_in(3, 11, "kbd ignored");
    i_host.reg_wr(REG_CTRL_STAT, 8'h40);
    i_host.reg_wr(REG_COUNT, 8'h05);
    idle_no_tmo(10, "kbd on wait");
    kbd_pulse();
    tmo_in(14, 24, "kbd restart");
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
  endtask : s_keyboard

  task automatic s_force_units;
    i_host.reg_wr(REG_COUNT, 8'h00);
    idle_no_tmo(60, "stopped timer");
    i_host.reg_wr(REG_CTRL_STAT, 8'h20);
    tmo_in(0, 3, "forced timeout");
    rd_chk(REG_CTRL_STAT, 8'h10, "force bit self clears");
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
    chk({7'h00, o_wdt_timeout}, 8'h00, "forced status clear");
    i_host.reg_wr(REG_UNIT_SEL, 8'h18);
    i_host.reg_wr(REG_COUNT, 8'h01);
    tmo_in(239, 244, "fast minutes");
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
    i_host.reg_wr(REG_UNIT_SEL, 8'h00);
    i_host.reg_wr(REG_COUNT, 8'h01);
    tmo_in(3999, 4004, "seconds");
    i_host.reg_wr(REG_COUNT, 8'h00);
    i_host.reg_wr(REG_CTRL_STAT, 8'h00);
  endtask : s_force_units

  task automatic s_lock;
    i_host.reg_wr(REG_UNIT_SEL, 8'h10);
    i_host.lock();
    chk({7'h00, o_cfg_mode}, 8'h00, "lock");
    i_host.reg_wr(REG_UNIT_SEL, 8'h08);
    rd_chk(REG_UNIT_SEL, OPEN_BUS, "locked data read");
    i_host.unlock();
    rd_chk(REG_UNIT_SEL, 8'h10, "kept while locked");
  endtask : s_lock

  task automatic give_verdict;
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(negedge i_clk_sys);
    s_reset_unlock();
    s_expire();
    s_keyboard();
    s_force_units();
    s_lock();
    give_verdict();
  end

  // Whole run is about 4600 cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    give_verdict();
  end
endmodule : testbench
